// ### core/aop_pkg.sv
// Constants shared by the output-processing configuration register bank.
package aop_pkg;

  // ---------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------
  localparam logic [7:0] IDX_COMMIT     = 8'h00;
  localparam logic [7:0] IDX_STATUS     = 8'h01;
  localparam logic [7:0] IDX_DEC_FILT   = 8'h41;
  localparam logic [7:0] IDX_ZONE       = 8'h42;
  localparam logic [7:0] IDX_CODING     = 8'h43;
  localparam logic [7:0] IDX_GAIN       = 8'h44;
  localparam logic [7:0] IDX_CODE_EN    = 8'h4b;
  localparam logic [7:0] IDX_DEC_EN     = 8'h4d;
  localparam logic [7:0] IDX_ZONE_EN    = 8'h4e;
  localparam logic [7:0] IDX_GAIN_REORD = 8'h52;
  localparam logic [7:0] IDX_REORD2     = 8'h72;

  // ---------------------------------------------------------------------
  // Storage table: slot order, index, writable bits and reset value
  // ---------------------------------------------------------------------
  localparam int NREG = 10;
  localparam int SLOT_COMMIT     = 0;
  localparam int SLOT_DEC_FILT   = 1;
  localparam int SLOT_ZONE       = 2;
  localparam int SLOT_CODING     = 3;
  localparam int SLOT_GAIN       = 4;
  localparam int SLOT_CODE_EN    = 5;
  localparam int SLOT_DEC_EN     = 6;
  localparam int SLOT_ZONE_EN    = 7;
  localparam int SLOT_GAIN_REORD = 8;
  localparam int SLOT_REORD2     = 9;

  localparam logic [7:0] REG_IDX [NREG] = '{
    IDX_COMMIT, IDX_DEC_FILT, IDX_ZONE, IDX_CODING, IDX_GAIN,
    IDX_CODE_EN, IDX_DEC_EN, IDX_ZONE_EN, IDX_GAIN_REORD, IDX_REORD2};
  localparam logic [7:0] REG_MASK [NREG] = '{
    8'h01, 8'h17, 8'h07, 8'h01, 8'hff, 8'h20, 8'h08, 8'h80, 8'h81, 8'h09};
  localparam logic [7:0] REG_RST [NREG] = '{
    8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int POS_COMMIT      = 0;
  localparam int POS_DEC_FILT_HI = 4;
  localparam int POS_DEC_EN      = 3;
  localparam int POS_ZONE_EN     = 7;
  localparam int POS_CODE_EN     = 5;
  localparam int POS_CODE_SEL    = 0;
  localparam int POS_GAIN_EN     = 0;
  localparam int POS_REORD1      = 7;
  localparam int POS_REORD2      = 3;
  localparam int POS_ST_LIVE     = 0;
  localparam int POS_ST_HP       = 1;
  localparam int POS_ST_BADFILT  = 2;
  localparam int POS_ST_ZONE_ON  = 3;
  localparam int POS_ST_BADZONE  = 4;
  localparam int POS_ST_OFFBIN   = 5;
  localparam int POS_ST_GAIN_ON  = 6;
  localparam int POS_ST_REORDER  = 7;

  // ---------------------------------------------------------------------
  // Codes and values
  // ---------------------------------------------------------------------
  localparam logic [3:0] DEC_CODE_LP = 4'ha;
  localparam logic [3:0] DEC_CODE_HP = 4'he;
  localparam logic [2:0] ZONE_FIRST  = 3'h0;
  localparam logic [2:0] ZONE_SECOND = 3'h1;
  localparam logic [2:0] ZONE_THIRD  = 3'h2;
  localparam logic [6:0] GAIN_UNITY  = 7'h20;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int         ADDR_W_MIN  = 10;

  typedef enum logic [1:0] {
    AOP_FILT_LP,
    AOP_FILT_HP,
    AOP_FILT_BAD
  } aop_filt_e;

endpackage

// ### core/aop_decode.sv
// Turns the committed register bytes into the settings the output path uses.
`timescale 1ns/100ps
`default_nettype none
module aop_decode
  import aop_pkg::*;
(
  input  wire logic [7:0] dec_filt,    // Decimation filter select byte.
  input  wire logic [7:0] dec_en,      // Decimation control enable byte.
  input  wire logic [7:0] zone,        // Sampling zone byte.
  input  wire logic [7:0] zone_en,     // Zone select enable byte.
  input  wire logic [7:0] coding,      // Output coding select byte.
  input  wire logic [7:0] code_en,     // Coding control enable byte.
  input  wire logic [7:0] gain,        // Gain code byte.
  input  wire logic [7:0] gain_reord,  // Gain apply and first unlock byte.
  input  wire logic [7:0] reord2,      // Second unlock byte.
  output aop_filt_e       filt,        // Filter response chosen.
  output logic            zone_on,     // Zone selection in force.
  output logic [2:0]      zone_idx,    // Zone number, zero based.
  output logic            zone_bad,    // Unused zone code selected.
  output logic            offset_bin,  // Offset binary coding in force.
  output logic            gain_on,     // Gain scaling in force.
  output logic [6:0]      gain_mult,   // Gain numerator over 32.
  output logic            reorder_on   // Lane reorder unlocked.
);

  logic [3:0] filt_code;

  // Filter select is split around a reserved bit; reassemble it first.
  always_comb begin
    filt_code = {dec_filt[POS_DEC_FILT_HI], dec_filt[2:0]};
    if (!dec_en[POS_DEC_EN]) begin
      filt = AOP_FILT_LP;
    end else begin
      case (filt_code)
        DEC_CODE_LP: filt = AOP_FILT_LP;
        DEC_CODE_HP: filt = AOP_FILT_HP;
        default:     filt = AOP_FILT_BAD;
      endcase
    end
  end

  // The zone number is the lower band edge counted in half-clock steps.
  always_comb begin
    zone_on  = zone_en[POS_ZONE_EN];
    zone_idx = zone_on ? zone[2:0] : ZONE_FIRST;
    zone_bad = zone_on && (zone[2:0] > ZONE_THIRD);
  end

  // Coding, gain and reorder unlock; the top gain bit never scales.
  always_comb begin
    offset_bin = code_en[POS_CODE_EN] & coding[POS_CODE_SEL];
    gain_on    = gain_reord[POS_GAIN_EN];
    gain_mult  = gain_on ? gain[6:0] : GAIN_UNITY;
    reorder_on = gain_reord[POS_REORD1] & reord2[POS_REORD2];
  end

endmodule
`default_nettype wire

// ### core/aop_regs.sv
// AXI4-Lite register bank with commit for the output-processing settings.
//
// Overview of operation
// - Decimation off means low-pass 2x; on: 1010 low-pass, 1110 high-pass.
// - Decimation enable bit 3 gates the filter select field.
// - Zone codes 000, 001, 010 are zones one to three; rest unused.
// - Each zone spans one half-clock band above the one before.
// - Zone field acts only while zone enable bit 7 is set.
// - Coding select gives twos complement at 0, offset binary at 1.
// - Coding enable bit 5 low forces twos complement output.
// - Gain is code over 32; code 7Fh gives about 12 dB.
// - Gain apply bit 0 low disables gain whatever the code.
// - Filter select is bit 4 and bits 2..0; low bits reset to 2.
// - Settings act only after the commit bit goes low-high-low.
`timescale 1ns/100ps
`default_nettype none
module aop_regs
  import aop_pkg::*;
#(
  parameter int ADDR_W = 12  // AXI address width in bits.
) (
  input  wire logic              aclk,          // Clock, 50 MHz.
  input  wire logic              aresetn,       // Synchronous reset, active low.
  input  wire logic              ce,            // Clock enable; low freezes all.
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // Write address.
  input  wire logic              s_axi_awvalid, // Write address valid.
  output logic                   s_axi_awready, // Write address ready.
  input  wire logic [31:0]       s_axi_wdata,   // Write data.
  input  wire logic [3:0]        s_axi_wstrb,   // Write byte strobes.
  input  wire logic              s_axi_wvalid,  // Write data valid.
  output logic                   s_axi_wready,  // Write data ready.
  output logic [1:0]             s_axi_bresp,   // Write response.
  output logic                   s_axi_bvalid,  // Write response valid.
  input  wire logic              s_axi_bready,  // Write response ready.
  input  wire logic [ADDR_W-1:0] s_axi_araddr,  // Read address.
  input  wire logic              s_axi_arvalid, // Read address valid.
  output logic                   s_axi_arready, // Read address ready.
  output logic [31:0]            s_axi_rdata,   // Read data.
  output logic [1:0]             s_axi_rresp,   // Read response.
  output logic                   s_axi_rvalid,  // Read data valid.
  input  wire logic              s_axi_rready,  // Read data ready.
  output logic                   filter_highpass,    // High-pass 2x selected.
  output logic                   filter_unsupported, // Unsupported filter code.
  output logic                   zone_select_on,     // Zone selection enabled.
  output logic [2:0]             zone_index,         // Zone, zero based.
  output logic                   zone_unused,        // Unused zone code.
  output logic                   offset_binary,      // Offset binary coding.
  output logic                   gain_on,            // Gain scaling applied.
  output logic [6:0]             gain_mult,          // Gain numerator over 32.
  output logic                   lane_reorder_on,    // Lane reorder unlocked.
  output logic                   config_live         // A commit has happened.
);

  // -----------------------------------------------------------------------
  // Elaboration checks
  // -----------------------------------------------------------------------
  if (ADDR_W < ADDR_W_MIN) begin : g_addr_check
    $error("ADDR_W too small to reach every register index");
  end

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  logic [7:0]        shadow [NREG];
  logic [7:0]        next_shadow [NREG];
  logic [7:0]        active [NREG];
  logic [7:0]        next_active [NREG];
  logic              next_config_live;
  logic              aw_full;
  logic              next_aw_full;
  logic [ADDR_W-1:0] awaddr_q;
  logic [ADDR_W-1:0] next_awaddr_q;
  logic              w_full;
  logic              next_w_full;
  logic [31:0]       wdata_q;
  logic [31:0]       next_wdata_q;
  logic [3:0]        wstrb_q;
  logic [3:0]        next_wstrb_q;
  logic              next_awready;
  logic              next_wready;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_arready;
  logic              next_rvalid;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;
  logic [7:0]        wr_idx;
  logic              wr_aligned;
  logic              wr_hit;
  logic [7:0]        rd_idx;
  logic              rd_aligned;
  logic              rd_hit;
  logic [7:0]        rd_byte;
  logic [7:0]        status_byte;

  // Decoder outputs, registered below so every port leaves a flip-flop.
  aop_filt_e         dec_filt;
  logic              dec_zone_on;
  logic [2:0]        dec_zone_idx;
  logic              dec_zone_bad;
  logic              dec_offset_bin;
  logic              dec_gain_on;
  logic [6:0]        dec_gain_mult;
  logic              dec_reorder_on;

  // -----------------------------------------------------------------------
  // Settings decoder, fed only from committed values
  // -----------------------------------------------------------------------
  aop_decode u_decode (
    .dec_filt   (active[SLOT_DEC_FILT]),
    .dec_en     (active[SLOT_DEC_EN]),
    .zone       (active[SLOT_ZONE]),
    .zone_en    (active[SLOT_ZONE_EN]),
    .coding     (active[SLOT_CODING]),
    .code_en    (active[SLOT_CODE_EN]),
    .gain       (active[SLOT_GAIN]),
    .gain_reord (active[SLOT_GAIN_REORD]),
    .reord2     (active[SLOT_REORD2]),
    .filt       (dec_filt),
    .zone_on    (dec_zone_on),
    .zone_idx   (dec_zone_idx),
    .zone_bad   (dec_zone_bad),
    .offset_bin (dec_offset_bin),
    .gain_on    (dec_gain_on),
    .gain_mult  (dec_gain_mult),
    .reorder_on (dec_reorder_on)
  );

  // -----------------------------------------------------------------------
  // Write channel: address and data are taken in either order, then the
  // store happens and the response is raised in the same edge.
  // -----------------------------------------------------------------------
  always_comb begin
    next_aw_full     = aw_full;
    next_awaddr_q    = awaddr_q;
    next_w_full      = w_full;
    next_wdata_q     = wdata_q;
    next_wstrb_q     = wstrb_q;
    next_bvalid      = s_axi_bvalid;
    next_bresp       = s_axi_bresp;
    next_shadow      = shadow;
    next_active      = active;
    next_config_live = config_live;
    wr_idx           = awaddr_q[9:2];
    wr_aligned       = ((awaddr_q >> 10) == '0) && (awaddr_q[1:0] == 2'h0);
    wr_hit           = 1'b0;
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full  = 1'b1;
      next_awaddr_q = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full  = 1'b1;
      next_wdata_q = s_axi_wdata;
      next_wstrb_q = s_axi_wstrb;
    end
    if (aw_full && w_full && !s_axi_bvalid) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      for (int i = 0; i < NREG; i++) begin
        if (wr_aligned && (wr_idx == REG_IDX[i])) begin
          wr_hit = 1'b1;
          // Only defined bits are kept; reserved bits drop here.
          if (wstrb_q[0]) begin
            next_shadow[i] = wdata_q[7:0] & REG_MASK[i];
          end
        end
      end
      // Status is read-only; a write there is accepted and dropped.
      if (wr_aligned && (wr_idx == IDX_STATUS)) begin
        wr_hit = 1'b1;
      end
      next_bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
      // The falling half of the commit pulse moves every setting at once,
      // so the output path never sees a half-written combination.
      if (wr_aligned && (wr_idx == IDX_COMMIT) && wstrb_q[0]
          && shadow[SLOT_COMMIT][POS_COMMIT]
          && !wdata_q[POS_COMMIT]) begin
        next_active      = next_shadow;
        next_config_live = 1'b1;
      end
    end
    next_awready = !next_aw_full && !next_bvalid;
    next_wready  = !next_w_full && !next_bvalid;
  end

  // -----------------------------------------------------------------------
  // Read channel: one read at a time, data one edge after the address.
  // -----------------------------------------------------------------------
  always_comb begin
    status_byte = 8'h00;
    status_byte[POS_ST_LIVE]    = config_live;
    status_byte[POS_ST_HP]      = filter_highpass;
    status_byte[POS_ST_BADFILT] = filter_unsupported;
    status_byte[POS_ST_ZONE_ON] = zone_select_on;
    status_byte[POS_ST_BADZONE] = zone_unused;
    status_byte[POS_ST_OFFBIN]  = offset_binary;
    status_byte[POS_ST_GAIN_ON] = gain_on;
    status_byte[POS_ST_REORDER] = lane_reorder_on;
    rd_idx     = s_axi_araddr[9:2];
    rd_aligned = ((s_axi_araddr >> 10) == '0) && (s_axi_araddr[1:0] == 2'h0);
    rd_hit     = 1'b0;
    rd_byte    = 8'h00;
    for (int i = 0; i < NREG; i++) begin
      if (rd_aligned && (rd_idx == REG_IDX[i])) begin
        rd_hit  = 1'b1;
        rd_byte = shadow[i];
      end
    end
    if (rd_aligned && (rd_idx == IDX_STATUS)) begin
      rd_hit  = 1'b1;
      rd_byte = status_byte;
    end
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = {24'h000000, rd_byte};
      next_rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    next_arready = !next_rvalid;
  end

  // -----------------------------------------------------------------------
  // Registers: bus state, shadow and committed settings, decoded outputs.
  // -----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full            <= 1'b0;
      awaddr_q           <= '0;
      w_full             <= 1'b0;
      wdata_q            <= 32'h00000000;
      wstrb_q            <= 4'h0;
      s_axi_awready      <= 1'b0;
      s_axi_wready       <= 1'b0;
      s_axi_bvalid       <= 1'b0;
      s_axi_bresp        <= RESP_OKAY;
      s_axi_arready      <= 1'b0;
      s_axi_rvalid       <= 1'b0;
      s_axi_rdata        <= 32'h00000000;
      s_axi_rresp        <= RESP_OKAY;
      config_live        <= 1'b0;
      shadow             <= REG_RST;
      active             <= REG_RST;
      filter_highpass    <= 1'b0;
      filter_unsupported <= 1'b0;
      zone_select_on     <= 1'b0;
      zone_index         <= ZONE_FIRST;
      zone_unused        <= 1'b0;
      offset_binary      <= 1'b0;
      gain_on            <= 1'b0;
      gain_mult          <= GAIN_UNITY;
      lane_reorder_on    <= 1'b0;
    end else if (ce) begin
      aw_full            <= next_aw_full;
      awaddr_q           <= next_awaddr_q;
      w_full             <= next_w_full;
      wdata_q            <= next_wdata_q;
      wstrb_q            <= next_wstrb_q;
      s_axi_awready      <= next_awready;
      s_axi_wready       <= next_wready;
      s_axi_bvalid       <= next_bvalid;
      s_axi_bresp        <= next_bresp;
      s_axi_arready      <= next_arready;
      s_axi_rvalid       <= next_rvalid;
      s_axi_rdata        <= next_rdata;
      s_axi_rresp        <= next_rresp;
      config_live        <= next_config_live;
      shadow             <= next_shadow;
      active             <= next_active;
      filter_highpass    <= (dec_filt == AOP_FILT_HP);
      filter_unsupported <= (dec_filt == AOP_FILT_BAD);
      zone_select_on     <= dec_zone_on;
      zone_index         <= dec_zone_idx;
      zone_unused        <= dec_zone_bad;
      offset_binary      <= dec_offset_bin;
      gain_on            <= dec_gain_on;
      gain_mult          <= dec_gain_mult;
      lane_reorder_on    <= dec_reorder_on;
    end
  end

endmodule
`default_nettype wire

// ### bench/aop_regs_asserts.sv
// Concurrent checks on the ports of the output-processing register bank.
`timescale 1ns/100ps
`default_nettype none
module aop_regs_asserts
  import aop_pkg::*;
(
  input wire logic        aclk,               // Clock.
  input wire logic        aresetn,            // Reset, active low.
  input wire logic        ce,                 // Clock enable.
  input wire logic        s_axi_awvalid,      // Write address valid.
  input wire logic        s_axi_awready,      // Write address ready.
  input wire logic        s_axi_wvalid,       // Write data valid.
  input wire logic        s_axi_wready,       // Write data ready.
  input wire logic [1:0]  s_axi_bresp,        // Write response.
  input wire logic        s_axi_bvalid,       // Write response valid.
  input wire logic        s_axi_bready,       // Write response ready.
  input wire logic        s_axi_arvalid,      // Read address valid.
  input wire logic        s_axi_arready,      // Read address ready.
  input wire logic [31:0] s_axi_rdata,        // Read data.
  input wire logic        s_axi_rvalid,       // Read data valid.
  input wire logic        s_axi_rready,       // Read data ready.
  input wire logic        filter_highpass,    // High-pass selected.
  input wire logic        filter_unsupported, // Unsupported filter code.
  input wire logic        zone_select_on,     // Zone selection enabled.
  input wire logic [2:0]  zone_index,         // Zone, zero based.
  input wire logic        zone_unused,        // Unused zone code.
  input wire logic        offset_binary,      // Offset binary coding.
  input wire logic        gain_on,            // Gain applied.
  input wire logic [6:0]  gain_mult,          // Gain numerator.
  input wire logic        lane_reorder_on,    // Lane reorder unlocked.
  input wire logic        config_live         // Committed once.
);
  // ---------------------------------------------------------------------
  // Bus handshake checks
  // ---------------------------------------------------------------------
  // One clock domain, so clock and reset are given once for all.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_read_latency: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
    else $error("Late read data.");
  a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready && ce |-> ##[1:2] s_axi_bvalid) else $error("Write answer came late.");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
    $stable(s_axi_bresp)) else $error("Response dropped.");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
    $stable(s_axi_rdata)) else $error("Read data dropped early.");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("Read taken while busy.");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("Write taken while busy.");

  // ---------------------------------------------------------------------
  // Decoded setting checks
  // ---------------------------------------------------------------------
  a_filter_excl: assert property (!(filter_highpass && filter_unsupported))
    else $error("Filter flags clash.");
  a_zone_gate: assert property (!zone_select_on |-> zone_index == 3'h0 && !zone_unused)
    else $error("Zone on while off.");
  a_zone_unused: assert property (zone_select_on |-> zone_unused == (zone_index > ZONE_THIRD))
    else $error("Unused zone flag wrong.");
  a_gain_gate: assert property (!gain_on |-> gain_mult == GAIN_UNITY)
    else $error("Gain on while off.");
  // Coding, gain and reorder settings may only move in the cycle after a write response.
  a_commit_only: assert property ($changed(offset_binary) || $changed(gain_on) ||
    $changed(lane_reorder_on) |-> $past(s_axi_bvalid)) else $error("Setting moved alone.");
  a_not_live: assert property (!config_live |-> !filter_highpass && !lane_reorder_on &&
    !offset_binary && !gain_on) else $error("Setting before commit.");

  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_highpass: cover property (filter_highpass);
  c_reorder: cover property (lane_reorder_on);
endmodule

bind aop_regs aop_regs_asserts u_chk (.*);
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking testbench for the output-processing register bank.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import aop_pkg::*;
;
  logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, filter_highpass, filter_unsupported;
  logic        zone_select_on, zone_unused, offset_binary, gain_on, lane_reorder_on;
  logic        config_live;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  zone_index;
  logic [3:0]  s_axi_wstrb;
  logic [6:0]  gain_mult;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          failures = 0, total_checks = 0;

  aop_regs #(.ADDR_W(12)) dut (.*);

  // 50 MHz clock.
  always #10 aclk = ~aclk;

  // ---------------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------------
  function automatic logic [11:0] ba(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic timeout();
    failures++;
    $display("CHECK FAILED at %0t: bus wait ran out", $time);
    summarize();
  endtask

  // Address and data go out together; each drops when taken.
  task automatic axi_write(input logic [11:0] a, logic [7:0] d, logic [1:0] rsp);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 20) timeout();
    else check(32'(s_axi_bresp), 32'(rsp));
  endtask

  task automatic axi_read(input logic [11:0] a, logic [7:0] d, logic [1:0] rsp);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 20) timeout();
    else begin
      check(s_axi_rdata, {24'h0, d});
      check(32'(s_axi_rresp), 32'(rsp));
    end
  endtask

  // Writes two registers, then pulses the commit bit low-high-low.
  task automatic cfg(input logic [7:0] ia, va, ib, vb);
    axi_write(ba(ia), va, RESP_OKAY);
    axi_write(ba(ib), vb, RESP_OKAY);
    axi_write(ba(IDX_COMMIT), 8'h01, RESP_OKAY);
    axi_write(ba(IDX_COMMIT), 8'h00, RESP_OKAY);
    repeat (2) @(posedge aclk);
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_reset();
    check(32'(gain_mult), 32'(GAIN_UNITY));
    check(32'(config_live), 32'h0);
    for (int i = 0; i < NREG; i++) axi_read(ba(REG_IDX[i]), REG_RST[i], RESP_OKAY);
  endtask

  // Shadow values reach the outputs only on commit.
  task automatic t_commit();
    axi_write(ba(IDX_CODE_EN), 8'h20, RESP_OKAY);
    axi_write(ba(IDX_CODING), 8'h01, RESP_OKAY);
    repeat (3) @(posedge aclk);
    check(32'(offset_binary), 32'h0);
    axi_read(ba(IDX_CODING), 8'h01, RESP_OKAY);
    cfg(IDX_CODING, 8'h01, IDX_CODE_EN, 8'h20);
    check(32'(offset_binary), 32'h1);
    check(32'(config_live), 32'h1);
    axi_read(ba(IDX_STATUS), 8'h21, RESP_OKAY);
  endtask

  // All-ones writes keep only the defined bits.
  task automatic t_regs();
    for (int i = 0; i < NREG; i++) begin
      axi_write(ba(REG_IDX[i]), 8'hff, RESP_OKAY);
      axi_read(ba(REG_IDX[i]), REG_MASK[i], RESP_OKAY);
      axi_write(ba(REG_IDX[i]), REG_RST[i], RESP_OKAY);
    end
  endtask

  task automatic t_filter();
    logic [7:0] r [5] = '{8'h0e, 8'h8a, 8'h8e, 8'h8f, 8'h83};
    logic [3:0] c;
    logic       en;
    foreach (r[i]) begin
      c = r[i][3:0];
      en = r[i][7];
      cfg(IDX_DEC_FILT, {3'h0, c[3], 1'b0, c[2:0]}, IDX_DEC_EN, {4'h0, en, 3'h0});
      check(32'(filter_highpass), 32'(en && c == DEC_CODE_HP));
      check(32'(filter_unsupported), 32'(en && c != DEC_CODE_LP && c != DEC_CODE_HP));
    end
  endtask

  task automatic t_zone();
    logic [7:0] r [5] = '{8'h01, 8'h80, 8'h81, 8'h82, 8'h85};
    logic [7:0] g [5] = '{8'h7f, 8'hff, 8'h85, 8'ha0, 8'h80};
    foreach (r[i]) begin
      cfg(IDX_ZONE, {5'h0, r[i][2:0]}, IDX_ZONE_EN, {r[i][7], 7'h0});
      check(32'(zone_select_on), 32'(r[i][7]));
      check(32'(zone_index), 32'(r[i][7] ? r[i][2:0] : ZONE_FIRST));
      check(32'(zone_unused), 32'(r[i][7] && r[i][2:0] > ZONE_THIRD));
      cfg(IDX_GAIN, {1'b0, g[i][6:0]}, IDX_GAIN_REORD, {7'h0, g[i][7]});
      check(32'(gain_on), 32'(g[i][7]));
      check(32'(gain_mult), 32'(g[i][7] ? g[i][6:0] : GAIN_UNITY));
    end
  endtask

  task automatic t_coding();
    logic [1:0] r [3] = '{2'b01, 2'b10, 2'b11};
    foreach (r[i]) begin
      cfg(IDX_CODING, {7'h0, r[i][0]}, IDX_CODE_EN, {2'h0, r[i][1], 5'h0});
      check(32'(offset_binary), 32'(r[i][1] & r[i][0]));
      cfg(IDX_GAIN_REORD, {r[i][1], 7'h0}, IDX_REORD2, {4'h0, r[i][0], 3'h0});
      check(32'(lane_reorder_on), 32'(&r[i]));
    end
  endtask

  // Unmapped, misaligned and out-of-range addresses are refused.
  task automatic t_bus();
    axi_read(ba(8'h50), 8'h00, RESP_SLVERR);
    axi_write(ba(8'h50), 8'h01, RESP_SLVERR);
    axi_read(ba(IDX_GAIN) | 12'h001, 8'h00, RESP_SLVERR);
    axi_write(ba(IDX_GAIN) | 12'h400, 8'h11, RESP_SLVERR);
    axi_read(ba(IDX_GAIN), 8'h00, RESP_OKAY);
  endtask

  // Reset for two cycles, then each scenario.
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    ce = 1'b1;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_commit();
    t_regs();
    t_filter();
    t_zone();
    t_coding();
    t_bus();
    summarize();
  end
endmodule
`default_nettype wire
